// ---- pkg/cgsm_pkg.sv ----
/*
  cgsm_pkg: shared types and constants for the clock-gating state controller.
  Assumes a single 50 MHz bus clock; no software-visible registers.
*/
package cgsm_pkg;

  // power states of the controller
  typedef enum logic [2:0] {
    ST_NORMAL    = 3'b000,
    ST_ACK_ISSUE = 3'b001,
    ST_ACK_WAIT  = 3'b010,
    ST_ENTRY     = 3'b011,
    ST_GATED     = 3'b100,
    ST_GATED_SNP = 3'b101,
    ST_HALTED    = 3'b110,
    ST_HALT_SNP  = 3'b111
  } cgsm_state_type;

  // latched wake events: management irq, soft init, two local irq pins
  typedef struct packed {
    logic       mgmt;
    logic       init;
    logic [1:0] lint;
  } cgsm_evt_type;

  // bus clocks from acknowledge response completion to gated state
  localparam int unsigned ENTRY_DELAY_CLKS = 20;
  localparam int unsigned ENTRY_CNT_W = 5;
  localparam logic [4:0] ENTRY_CNT_RST = 5'h00;
  localparam cgsm_evt_type EVT_NONE = '{mgmt: 1'b0, init: 1'b0, lint: 2'h0};

endpackage : cgsm_pkg

// ---- verilog/cgsm_ctrl.sv ----
/*
  cgsm_ctrl: low-power state controller for the clock-gated state and the
  snoop sub-states of the gated and halted states.
  Assumes: bus-side pins (stop request, irq pins, snoop) arrive asynchronously
  and are synchronised here; ack cycle issue and core halt come from logic on
  the same clock; i_srst is the processor reset, synchronous, active high.
*/
// How it works
// RULE1: on stop request issue gate-ack bus cycle; gate 20 clocks after its response.
// RULE2: chipset leaves terminated bus lines undriven while gated.
// RULE3: chipset holds other bus inputs inactive while gated.
// RULE4: reset while gated reinitialises but stays gated.
// RULE5: deasserting the stop request returns from gated to normal.
// RULE6: snoop seen while gated moves to gated snoop state.
// RULE7: latch irq, init and local irq pins while gated; service in normal.
// RULE8: at most one occurrence of each latched event is delivered.
// RULE9: snoops are answered from both gated and halted states.
// RULE10: stay in snoop sub-state until the snoop is serviced by anyone.
// RULE11: after servicing, return to the low-power state left.
// RULE12: halted returns to normal on management irq, init or local irq.
// RULE13: stop request raised while halted returns to halted afterwards.
// RULE14: stop request sampled as a level on the bus clock.
`timescale 1ns/10ps
module cgsm_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_stop_clock_request_n,
  input wire logic i_system_mgmt_irq_n,
  input wire logic i_soft_init_n,
  input wire logic [1:0] i_local_irq_pins,
  input wire logic i_snoop_start,
  input wire logic i_snoop_done,
  input wire logic i_halt_entry,
  input wire logic i_ack_granted,
  input wire logic i_ack_resp_done,
  input wire logic i_evt_taken,
  output logic o_ack_cycle_req,
  output logic o_clock_gated,
  output logic o_halted,
  output logic o_snoop_active,
  output cgsm_pkg::cgsm_evt_type o_evt_pending,
  output logic o_evt_valid,
  output logic o_core_init
);

  // two-flop synchronisers for event and snoop pins; only stage 2 is read
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic snp_s1_q;
  logic snp_s2_q;
  logic snpd_s1_q;
  logic snpd_s2_q;
  logic stop_s1_q;
  logic stop_s2_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      snp_s1_q <= 1'b0;
      snp_s2_q <= 1'b0;
      snpd_s1_q <= 1'b0;
      snpd_s2_q <= 1'b0;
    end else begin
      sync1_q <= {i_system_mgmt_irq_n, i_soft_init_n, ~i_local_irq_pins};
      sync2_q <= sync1_q;
      snp_s1_q <= i_snoop_start;
      snp_s2_q <= snp_s1_q;
      snpd_s1_q <= i_snoop_done;
      snpd_s2_q <= snpd_s1_q;
    end
  end

  // stop request synchroniser has no reset: forcing it inactive would read
  // as a stop release and drop the gated state right after a reset
  always_ff @(posedge i_clk_sys) begin
    stop_s1_q <= i_stop_clock_request_n;
    stop_s2_q <= stop_s1_q;
  end

  // active-high views of synchronised pins; stop request is a level, so a
  // glitch shorter than a clock reaches the state machine only if it spans a clock edge
  wire stop_req = ~stop_s2_q; // see RULE14
  cgsm_pkg::cgsm_evt_type evt_lvl;
  assign evt_lvl = '{mgmt: ~sync2_q[3], init: ~sync2_q[2], lint: ~sync2_q[1:0]};

  // rising-edge detect on events, so a held pin counts once
  cgsm_pkg::cgsm_evt_type evt_prev_q;
  cgsm_pkg::cgsm_evt_type evt_rise;
  assign evt_rise = evt_lvl & ~evt_prev_q;
  wire any_rise = |evt_rise;

  cgsm_pkg::cgsm_state_type state_q;
  cgsm_pkg::cgsm_state_type state_d;
  logic came_from_halt_q;
  logic came_from_halt_d;
  logic [cgsm_pkg::ENTRY_CNT_W-1:0] cnt_q;
  logic [cgsm_pkg::ENTRY_CNT_W-1:0] cnt_d;
  logic gated_q;
  cgsm_pkg::cgsm_evt_type pend_q;
  cgsm_pkg::cgsm_evt_type pend_d;

  localparam logic [4:0] ENTRY_LAST = 5'(cgsm_pkg::ENTRY_DELAY_CLKS - 1);

  // gated decode, shared by the state view and the registered gate flag
  function automatic logic is_gated(input cgsm_pkg::cgsm_state_type st);
    return (st == cgsm_pkg::ST_GATED) || (st == cgsm_pkg::ST_GATED_SNP);
  endfunction : is_gated

  wire in_gated = is_gated(state_q);

  // two-state copy for the reset decision: an unknown power-up state reads
  // as not gated, so the first reset always settles in normal
  bit rst_keep_gated;
  assign rst_keep_gated = in_gated;
  wire in_halt = (state_q == cgsm_pkg::ST_HALTED) || (state_q == cgsm_pkg::ST_HALT_SNP);

  // next-state logic
  always_comb begin
    state_d = state_q;
    came_from_halt_d = came_from_halt_q;
    cnt_d = cnt_q;
    unique case (state_q)
      cgsm_pkg::ST_NORMAL: begin
        if (stop_req) begin
          state_d = cgsm_pkg::ST_ACK_ISSUE; // see RULE1
          came_from_halt_d = 1'b0;
        end else if (i_halt_entry) begin
          state_d = cgsm_pkg::ST_HALTED;
        end
      end
      cgsm_pkg::ST_ACK_ISSUE: begin
        if (i_ack_granted) begin
          state_d = cgsm_pkg::ST_ACK_WAIT;
        end
      end
      cgsm_pkg::ST_ACK_WAIT: begin
        if (i_ack_resp_done) begin
          state_d = cgsm_pkg::ST_ENTRY;
          cnt_d = cgsm_pkg::ENTRY_CNT_RST;
        end
      end
      cgsm_pkg::ST_ENTRY: begin
        // bus still alive during the countdown, so the ack stays committed
        if (cnt_q == ENTRY_LAST) begin
          state_d = cgsm_pkg::ST_GATED; // see RULE1
        end else begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      cgsm_pkg::ST_GATED: begin
        if (!stop_req) begin
          state_d = came_from_halt_q ? cgsm_pkg::ST_HALTED : cgsm_pkg::ST_NORMAL; // see RULE5 see RULE13
        end else if (snp_s2_q) begin
          state_d = cgsm_pkg::ST_GATED_SNP; // see RULE6 see RULE9
        end
      end
      cgsm_pkg::ST_GATED_SNP: begin
        if (snpd_s2_q) begin
          state_d = cgsm_pkg::ST_GATED; // see RULE10 see RULE11
        end
      end
      cgsm_pkg::ST_HALTED: begin
        if (stop_req) begin
          state_d = cgsm_pkg::ST_ACK_ISSUE;
          came_from_halt_d = 1'b1; // see RULE13
        end else if (any_rise) begin
          state_d = cgsm_pkg::ST_NORMAL; // see RULE12
        end else if (snp_s2_q) begin
          state_d = cgsm_pkg::ST_HALT_SNP; // see RULE9
        end
      end
      cgsm_pkg::ST_HALT_SNP: begin
        if (snpd_s2_q) begin
          state_d = cgsm_pkg::ST_HALTED; // see RULE10 see RULE11
        end
      end
    endcase
  end

  // pending events: set while gated, one bit per event, so repeats fold into
  // one; the set beats a same-cycle take by the core
  always_comb begin
    pend_d = pend_q;
    if (o_evt_valid && i_evt_taken) begin
      pend_d = cgsm_pkg::EVT_NONE; // see RULE8
    end
    if (in_gated) begin
      pend_d = pend_d | evt_rise; // see RULE7
    end
  end

  // state registers; reset while gated keeps the gated state, clearing its halt
  // return, the snoop sub-state and pending events
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_q <= rst_keep_gated ? cgsm_pkg::ST_GATED : cgsm_pkg::ST_NORMAL; // see RULE4
      came_from_halt_q <= 1'b0;
      cnt_q <= cgsm_pkg::ENTRY_CNT_RST;
      pend_q <= cgsm_pkg::EVT_NONE;
      evt_prev_q <= cgsm_pkg::EVT_NONE;
      gated_q <= rst_keep_gated;
    end else begin
      state_q <= state_d;
      came_from_halt_q <= came_from_halt_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      evt_prev_q <= evt_lvl;
      gated_q <= is_gated(state_d);
    end
  end

  // init pulse to the core, high for each reset clock, when reset lands in the gated state
  logic core_init_q;
  always_ff @(posedge i_clk_sys) begin
    core_init_q <= i_srst & rst_keep_gated; // see RULE4
  end

  // outputs; pending events are held back until normal state
  assign o_ack_cycle_req = (state_q == cgsm_pkg::ST_ACK_ISSUE);
  assign o_clock_gated = gated_q;
  assign o_halted = in_halt;
  assign o_snoop_active = (state_q == cgsm_pkg::ST_GATED_SNP) || (state_q == cgsm_pkg::ST_HALT_SNP);
  assign o_evt_pending = pend_q;
  assign o_evt_valid = (state_q == cgsm_pkg::ST_NORMAL) && (|pend_q); // see RULE7 see RULE8
  assign o_core_init = core_init_q;

endmodule : cgsm_ctrl

// ---- test/cgsm_monitor.sv ----
/* cgsm_monitor: port checks on the clock-gating controller.
   assumes a bind to cgsm_ctrl, one clock i_clk_sys, sync reset i_srst */
`timescale 1ns/10ps
module cgsm_monitor (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_stop_clock_request_n,
  input wire logic i_snoop_done,
  input wire logic i_ack_granted,
  input wire logic i_ack_resp_done,
  input wire logic i_evt_taken,
  input wire logic o_ack_cycle_req,
  input wire logic o_clock_gated,
  input wire logic o_halted,
  input wire logic o_snoop_active,
  input wire cgsm_pkg::cgsm_evt_type o_evt_pending,
  input wire logic o_evt_valid,
  input wire logic o_core_init
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // gate flag is low on the last of the 20 entry clocks, then rises
  sequence s_entry;
    ##19 !o_clock_gated ##1 o_clock_gated;
  endsequence
  a_entry_delay: assert property (i_ack_resp_done |=> s_entry)
    else $error("gate entry timing wrong");
  a_ack_hold: assert property (o_ack_cycle_req && !i_ack_granted |=> o_ack_cycle_req)
    else $error("ack request dropped early");
  a_gate_exit: assert property ($rose(i_stop_clock_request_n) && o_clock_gated && !o_snoop_active |-> ##[1:4] !o_clock_gated)
    else $error("gated state not left");
  // reset must not take the part out of the gated state
  a_reset_gated: assert property (disable iff (1'b0) i_srst && o_clock_gated |=> o_clock_gated && o_core_init)
    else $error("reset left gated state");
  a_snoop_hold: assert property (o_snoop_active && !i_snoop_done |=> o_snoop_active)
    else $error("snoop state left early");
  a_snoop_back: assert property ($fell(o_snoop_active) |-> o_clock_gated == $past(o_clock_gated) && o_halted == $past(o_halted))
    else $error("wrong state after snoop");
  a_valid_normal: assert property (o_evt_valid |-> !o_clock_gated && !o_halted && o_evt_pending != cgsm_pkg::EVT_NONE)
    else $error("event offered outside normal");
  a_take_clear: assert property (o_evt_valid && i_evt_taken |=> o_evt_pending == cgsm_pkg::EVT_NONE)
    else $error("taken events not cleared");
endmodule : cgsm_monitor
bind cgsm_ctrl cgsm_monitor u_mon (.*);

// ---- test/cgsm_chipset_model.sv ----
/* cgsm_chipset_model: chipset side of the gate-ack special cycle.
   assumes the request stands until the cycle after the grant */
`timescale 1ns/10ps
module cgsm_chipset_model #(parameter int GAP = 3) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ack_req,
  output logic o_granted,
  output logic o_resp_done
);
  logic [7:0] cnt_q;
  // grant once, end the response GAP+1 clocks after the grant; lines idle low otherwise
  always_ff @(posedge i_clk_sys) begin
    o_granted <= !i_srst && i_ack_req && !o_granted && cnt_q == 8'h00;
    o_resp_done <= cnt_q == 8'h01;
    if (i_srst) cnt_q <= 8'h00;
    else if (o_granted) cnt_q <= 8'(GAP);
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
endmodule : cgsm_chipset_model

// ---- test/cgsm_ctrl_tb.sv ----
/* cgsm_ctrl_tb: directed bench for the clock-gating controller.
   assumes a 50 MHz bus clock and the chipset model for the ack cycle */
`timescale 1ns/10ps
module cgsm_ctrl_tb;
  logic i_clk_sys = 1'b0, i_srst = 1'b1, i_stop_clock_request_n = 1'b1, i_system_mgmt_irq_n = 1'b1;
  logic i_soft_init_n = 1'b1, i_snoop_start = 1'b0, i_snoop_done = 1'b0, i_halt_entry = 1'b0, i_evt_taken = 1'b0;
  logic [1:0] i_local_irq_pins = 2'h0;
  wire logic i_ack_granted, i_ack_resp_done, o_ack_cycle_req, o_clock_gated, o_halted, o_snoop_active;
  wire logic o_evt_valid, o_core_init;
  wire cgsm_pkg::cgsm_evt_type o_evt_pending;
  int bad_count = 0, checked = 0, n;
  always #10 i_clk_sys = ~i_clk_sys;
  cgsm_ctrl DUT (.*);
  cgsm_chipset_model u_chip (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ack_req(o_ack_cycle_req),
    .o_granted(i_ack_granted), .o_resp_done(i_ack_resp_done));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk_sys);
  endtask : tick
  // bounded wait on one output; a stuck design ends the run
  function automatic logic sel(input int w);
    case (w)
      0: return i_ack_resp_done;
      1: return o_clock_gated;
      2: return o_snoop_active;
      default: return o_halted;
    endcase
  endfunction : sel
  task automatic await(input int w, input logic v);
    for (n = 0; n < 300 && sel(w) !== v; n++) begin
      tick(1);
      #1;
    end
    if (n == 300) begin
      bad_count++;
      wrap_up();
    end
  endtask : await
  task automatic t_entry;
    tick(1);
    i_stop_clock_request_n <= 1'b0;
    tick(3);
    #1 chk(o_ack_cycle_req, 1'b1);
    await(0, 1'b1);
    tick(20);
    #1 chk(o_clock_gated, 1'b0);
    tick(1);
    #1 chk(o_clock_gated, 1'b1);
  endtask : t_entry
  // reset, doubled events and a snoop while gated, then release
  task automatic t_gated;
    tick(1);
    i_srst <= 1'b1;
    tick(1);
    i_srst <= 1'b0;
    #1 chk({o_clock_gated, o_core_init}, 8'h03);
    repeat (2) begin
      tick(3);
      i_system_mgmt_irq_n <= 1'b0;
      i_local_irq_pins <= 2'h1;
      tick(3);
      i_system_mgmt_irq_n <= 1'b1;
      i_local_irq_pins <= 2'h0;
    end
    i_snoop_start <= 1'b1;
    await(2, 1'b1);
    chk(o_clock_gated, 1'b1);
    tick(1);
    i_snoop_start <= 1'b0;
    i_snoop_done <= 1'b1;
    await(2, 1'b0);
    chk(o_clock_gated, 1'b1);
    tick(1);
    i_snoop_done <= 1'b0;
    i_stop_clock_request_n <= 1'b1;
    await(1, 1'b0);
    chk({o_halted, o_evt_valid, o_evt_pending}, 8'h19);
    tick(1);
    i_evt_taken <= 1'b1;
    tick(1);
    i_evt_taken <= 1'b0;
    #1 chk(o_evt_valid, 1'b0);
  endtask : t_gated
  // snoop and stop request from halted, then wake on a local irq
  task automatic t_halt;
    tick(1);
    i_halt_entry <= 1'b1;
    tick(1);
    i_halt_entry <= 1'b0;
    i_snoop_start <= 1'b1;
    await(2, 1'b1);
    chk(o_halted, 1'b1);
    tick(1);
    i_snoop_start <= 1'b0;
    i_snoop_done <= 1'b1;
    await(2, 1'b0);
    chk(o_halted, 1'b1);
    tick(1);
    i_snoop_done <= 1'b0;
    t_entry();
    tick(1);
    i_stop_clock_request_n <= 1'b1;
    await(1, 1'b0);
    chk(o_halted, 1'b1);
    tick(1);
    i_local_irq_pins <= 2'h2;
    await(3, 1'b0);
    chk(o_evt_valid, 1'b0);
  endtask : t_halt
  initial begin
    tick(16);
    i_srst <= 1'b0;
    t_entry();
    t_gated();
    t_halt();
    wrap_up();
  end
endmodule : cgsm_ctrl_tb
